// ===== core/timer8_waveform_generator.sv
`timescale 1ns/1ps
// What this block does
// R01: phase correct mode counts up bottom to 0xff then down, repeatedly.
// R02: phase correct holds max for one timer tick, then counts down.
// R03: phase correct mode 2 clears on up match, sets on down match.
// R04: overflow flag set at bottom in phase correct, at max otherwise.
// R05: top is 0xff except clear-on-compare, where top is compare value.
// R06: compare writes act at once in non-pwm, load at top in pwm.
// R07: phase correct mode 2 compare at bottom gives low, at max gives high.
// R08: leaving max compare, output at max follows the up-match result.
// R09: a missed up match still produces its output transition.
// R10: fully synchronous; selected timer clock only enables counting.
// R11: force strobe in non-pwm mode forces an immediate output match.
// R12: forced match sets no flag and never clears the counter.
// R13: force strobe is stateless and always reads zero.
// R14: software writes force strobe as zero while a pwm mode runs.
// R15: waveform mode bits sit at positions 6 and 3.
// R16: nonzero compare output mode overrides port value; direction enables.
// R17: non-pwm output: off, toggle, clear or set on match.
// R18: fast pwm: clear on match set at top, or inverse.
// R19: phase correct output mode 1 is reserved.
// R20: pwm compare equal top with high mode bit acts only at top.
// R21: clock select: stop, 1, 8, 64, 256, 1024, ext fall, ext rise.
// R22: external pin edges count even when the pin is an output.
// R23: a count write blocks compare match on the next timer tick.
// R24: flags clear on vector acknowledge or by writing one.
// R25: clear-on-compare resets counter on the tick where count equals compare.
// R26: fast pwm counts to max then clears to bottom.
// R27: compare flag set on the tick where count equals compare.
module timer8_waveform_generator (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clock_enable,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        external_count_pin,
  input  wire logic        compare_vector_ack,
  input  wire logic        overflow_vector_ack,
  output logic             compare_pin_out,
  output logic             compare_pin_oe,
  output logic             compare_flag,
  output logic             overflow_flag
);

  timer8_pkg::control_type ctrl_q;
  timer8_pkg::bus_req_type req_q;
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic        hreadyout_q;
  logic [31:0] hrdata_q;
  logic [7:0]  count_q;
  logic [7:0]  count_d;
  logic        dir_up_q;
  logic        dir_up_d;
  logic [7:0]  ocr_q;
  logic [7:0]  ocr_buf_q;
  logic        block_q;
  logic        oc_q;
  logic        oc_d;
  logic        cmp_flag_q;
  logic        ovf_flag_q;
  logic        port_value_q;
  logic        port_dir_q;
  logic        pin_q;
  logic        oe_q;
  logic [9:0]  pre_q;
  logic        ext_s1_q;
  logic        ext_s2_q;
  logic        ext_s3_q;
  logic [31:0] rd_mux;
  wire         haddr_ok = 1'b1;

  // bus decode
  wire addr_phase = hsel & htrans[1] & hready;
  wire wr_ctrl  = wr_pend_q & (req_q.addr == timer8_pkg::control_offset);
  wire wr_count = wr_pend_q & (req_q.addr == timer8_pkg::count_offset);
  wire wr_comp  = wr_pend_q & (req_q.addr == timer8_pkg::compare_offset);
  wire wr_flags = wr_pend_q & (req_q.addr == timer8_pkg::flags_offset);
  wire wr_port  = wr_pend_q & (req_q.addr == timer8_pkg::port_offset);
  wire timer8_pkg::control_type wctrl = hwdata[7:0];

  // mode decode, bits 6 and 3 form the mode code
  wire timer8_pkg::mode_type mode =
    timer8_pkg::mode_type'({ctrl_q.waveform_mode_high_bit,
                            ctrl_q.waveform_mode_low_bit}); // see R15
  wire [1:0] com     = ctrl_q.compare_output_mode;
  wire is_pwm        = ctrl_q.waveform_mode_low_bit;
  wire is_phase      = (mode == timer8_pkg::mode_phase);
  wire is_fast       = (mode == timer8_pkg::mode_fast);
  wire is_ctc        = (mode == timer8_pkg::mode_ctc);
  // force only in non-pwm mode as written; stored value is dropped
  wire force_cmp     = wr_ctrl & wctrl.force_compare_strobe
                       & ~wctrl.waveform_mode_low_bit; // see R11 R13

  // timer clock enable selection
  wire pre_8    = (pre_q & timer8_pkg::mask_div8) == timer8_pkg::mask_div8;
  wire pre_64   = (pre_q & timer8_pkg::mask_div64) == timer8_pkg::mask_div64;
  wire pre_256  = (pre_q & timer8_pkg::mask_div256)
                  == timer8_pkg::mask_div256;
  wire pre_1024 = (pre_q & timer8_pkg::mask_div1024)
                  == timer8_pkg::mask_div1024;
  // edge detect reads only the second and third stages
  wire ext_fall = ~ext_s2_q & ext_s3_q; // see R22
  wire ext_rise = ext_s2_q & ~ext_s3_q; // see R22
  logic tick;
  always_comb begin
    case (ctrl_q.clock_select) // see R21
      timer8_pkg::cs_stopped:  tick = 1'b0;
      timer8_pkg::cs_div1:     tick = 1'b1;
      timer8_pkg::cs_div8:     tick = pre_8;
      timer8_pkg::cs_div64:    tick = pre_64;
      timer8_pkg::cs_div256:   tick = pre_256;
      timer8_pkg::cs_div1024:  tick = pre_1024;
      timer8_pkg::cs_ext_fall: tick = ext_fall;
      timer8_pkg::cs_ext_rise: tick = ext_rise;
      default:                 tick = 1'b0;
    endcase
  end

  // compare and top detection
  wire at_max     = (count_q == timer8_pkg::max_value);
  wire at_bottom  = (count_q == timer8_pkg::bottom_value);
  wire equal      = (count_q == ocr_q);
  wire match      = tick & equal & ~block_q; // see R23 R27
  wire pwm_top    = tick & is_pwm & at_max & (~is_phase | dir_up_q);
  // top equals compare with high mode bit: match ignored in pwm
  wire top_ignore = is_pwm & (ocr_q == timer8_pkg::max_value)
                    & com[1]; // see R20
  // counting direction of a match at bottom counts as up
  wire match_up   = dir_up_q | at_bottom;
  wire ovf_event  = tick & (is_phase ? at_bottom : at_max); // see R04

  // next count and direction
  always_comb begin
    count_d  = count_q;
    dir_up_d = dir_up_q;
    if (tick) begin
      case (mode)
        timer8_pkg::mode_normal: count_d = count_q + 8'h01;
        timer8_pkg::mode_ctc: begin
          // top comes from compare value here; forced match never clears
          if (equal & ~block_q)
            count_d = timer8_pkg::bottom_value; // see R05 R25 R12
          else
            count_d = count_q + 8'h01;
        end
        timer8_pkg::mode_fast: count_d = count_q + 8'h01; // see R26
        timer8_pkg::mode_phase: begin
          // max and bottom are each seen for a single tick
          if (dir_up_q & at_max) begin
            count_d  = count_q - 8'h01; // see R01 R02
            dir_up_d = 1'b0;
          end else if (~dir_up_q & at_bottom) begin
            count_d  = count_q + 8'h01; // see R01
            dir_up_d = 1'b1;
          end else if (dir_up_q) begin
            count_d = count_q + 8'h01;
          end else begin
            count_d = count_q - 8'h01;
          end
        end
        default: count_d = count_q;
      endcase
    end
  end

  // waveform output
  always_comb begin
    oc_d = oc_q;
    if (~is_pwm) begin
      if (match) begin
        case (com) // see R17
          timer8_pkg::com_toggle: oc_d = ~oc_q;
          timer8_pkg::com_clear:  oc_d = 1'b0;
          timer8_pkg::com_set:    oc_d = 1'b1;
          default:                oc_d = oc_q;
        endcase
      end
    end else if (is_fast & com[1]) begin
      // mode 1 reserved: no output action
      if (pwm_top)
        oc_d = ~com[0]; // see R18 R20
      else if (match & ~top_ignore)
        oc_d = com[0]; // see R18
    end else if (is_phase & com[1]) begin
      if (pwm_top) begin
        // top reached: next compare value decides the level at max
        if (ocr_buf_q == timer8_pkg::max_value)
          oc_d = ~com[0]; // see R20 R07
        else
          oc_d = com[0]; // see R08 R09
      end else if (match & ~top_ignore) begin
        oc_d = match_up ? com[0] : ~com[0]; // see R03 R19 R07
      end
    end
    // forced action follows the output mode written with the strobe
    if (force_cmp) begin
      case (wctrl.compare_output_mode) // see R11
        timer8_pkg::com_toggle: oc_d = ~oc_q;
        timer8_pkg::com_clear:  oc_d = 1'b0;
        timer8_pkg::com_set:    oc_d = 1'b1;
        default:                oc_d = oc_q;
      endcase
    end
  end

  // bus slave; reads take one wait state so a prior write is seen
  always_ff @(posedge clock) begin
    if (reset) begin
      req_q       <= '0;
      wr_pend_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h0000_0000;
    end else if (clock_enable) begin
      wr_pend_q <= addr_phase & hwrite;
      rd_pend_q <= addr_phase & ~hwrite;
      if (addr_phase)
        req_q <= '{write: hwrite, addr: haddr[4:0]};
      if (addr_phase & ~hwrite)
        hreadyout_q <= 1'b0;
      else
        hreadyout_q <= 1'b1;
      if (rd_pend_q)
        hrdata_q <= rd_mux;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr_ok) begin
      case (req_q.addr)
        timer8_pkg::control_offset:
          rd_mux = {24'h000000, 1'b0, ctrl_q[6:0]}; // see R13
        timer8_pkg::count_offset:   rd_mux = {24'h000000, count_q};
        timer8_pkg::compare_offset: rd_mux = {24'h000000, ocr_buf_q};
        timer8_pkg::flags_offset:
          rd_mux = {30'h00000000, cmp_flag_q, ovf_flag_q};
        timer8_pkg::port_offset:
          rd_mux = {30'h00000000, port_dir_q, port_value_q};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end
  // control, compare, port registers
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_q       <= timer8_pkg::control_reset;
      ocr_q        <= timer8_pkg::compare_reset;
      ocr_buf_q    <= timer8_pkg::compare_reset;
      port_value_q <= 1'b0;
      port_dir_q   <= 1'b0;
    end else if (clock_enable) begin
      if (wr_ctrl)
        ctrl_q <= {1'b0, hwdata[6:0]}; // see R13
      if (wr_comp)
        ocr_buf_q <= hwdata[7:0];
      if (wr_comp & ~is_pwm)
        ocr_q <= hwdata[7:0]; // see R06
      else if (pwm_top)
        ocr_q <= ocr_buf_q; // see R06
      if (wr_port) begin
        port_value_q <= hwdata[timer8_pkg::port_value_bit];
        port_dir_q   <= hwdata[timer8_pkg::port_dir_bit];
      end
    end
  end

  // counter; a software write wins over the tick
  always_ff @(posedge clock) begin
    if (reset) begin
      count_q  <= timer8_pkg::count_reset;
      dir_up_q <= 1'b1;
      block_q  <= 1'b0;
      oc_q     <= 1'b0;
    end else if (clock_enable) begin // see R10
      count_q  <= wr_count ? hwdata[7:0] : count_d;
      dir_up_q <= dir_up_d;
      oc_q     <= oc_d;
      if (wr_count)
        block_q <= 1'b1; // see R23
      else if (tick)
        block_q <= 1'b0;
    end
  end

  // flags: set wins over any clear
  always_ff @(posedge clock) begin
    if (reset) begin
      cmp_flag_q <= 1'b0;
      ovf_flag_q <= 1'b0;
    end else if (clock_enable) begin
      cmp_flag_q <= match | (cmp_flag_q & ~compare_vector_ack
        & ~(wr_flags & hwdata[timer8_pkg::compare_flag_bit])); // see R24 R27
      ovf_flag_q <= ovf_event | (ovf_flag_q & ~overflow_vector_ack
        & ~(wr_flags & hwdata[timer8_pkg::overflow_flag_bit])); // see R24
    end
  end

  // prescaler, synchroniser and pin driver
  always_ff @(posedge clock) begin
    if (reset) begin
      pre_q    <= 10'h000;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      pin_q    <= 1'b0;
      oe_q     <= 1'b0;
    end else if (clock_enable) begin
      pre_q    <= pre_q + 10'h001;
      // pin sampled whatever its direction
      ext_s1_q <= external_count_pin; // see R22
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      pin_q    <= (com != timer8_pkg::com_off) ? oc_d : port_value_q;
      oe_q     <= port_dir_q; // see R16
    end
  end

  assign hreadyout       = hreadyout_q;
  assign hrdata          = hrdata_q;
  assign hresp           = 1'b0;
  assign compare_pin_out = pin_q;
  assign compare_pin_oe  = oe_q;
  assign compare_flag    = cmp_flag_q;
  assign overflow_flag   = ovf_flag_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_pc_turn;
    clock_enable & tick & is_phase & dir_up_q & at_max & ~wr_count
      |=> count_q == 8'hfe;
  endproperty
  a_pc_turn: assert property (p_pc_turn) else $error("no turn at max"); // see R02

  property p_ctc_clear;
    clock_enable & tick & is_ctc & equal & ~block_q & ~wr_count
      |=> count_q == 8'h00;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("ctc no clear"); // see R25

  property p_fast_wrap;
    clock_enable & tick & is_fast & at_max & ~wr_count |=> at_bottom;
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("fast no wrap"); // see R26

  property p_ovf_pc;
    clock_enable & tick & is_phase & at_bottom |=> ovf_flag_q;
  endproperty
  a_ovf_pc: assert property (p_ovf_pc) else $error("ovf not set"); // see R04

  property p_match_flag;
    clock_enable & tick & equal & ~block_q |=> cmp_flag_q;
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("no flag"); // see R27

  property p_force_noflag;
    clock_enable & force_cmp & ~tick & ~cmp_flag_q |=> ~cmp_flag_q;
  endproperty
  a_force_noflag: assert property (p_force_noflag) else $error("force flag"); // see R12

  property p_block;
    $past(wr_count & clock_enable) & tick |-> ~match;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked"); // see R23

  property p_ctrl_read;
    clock_enable & rd_pend_q & (req_q.addr == timer8_pkg::control_offset)
      |=> hreadyout_q & ~hrdata_q[7];
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("strobe read"); // see R13

  property p_nonpwm_set;
    clock_enable & ~is_pwm & match & (com == timer8_pkg::com_set) |=> oc_q;
  endproperty
  a_nonpwm_set: assert property (p_nonpwm_set) else $error("no set"); // see R17

  property p_pc_up_clear;
    clock_enable & is_phase & match & dir_up_q & ~top_ignore & ~pwm_top
      & (com == timer8_pkg::com_clear) |=> ~oc_q;
  endproperty
  a_pc_up_clear: assert property (p_pc_up_clear) else $error("no clr"); // see R03

  c_ctc: cover property (clock_enable & tick & is_ctc & equal);
  c_turn: cover property (clock_enable & pwm_top & is_phase);
  c_force: cover property (clock_enable & force_cmp);
  c_ovf: cover property (clock_enable & ovf_event);

endmodule

// ===== shared/timer8_pkg.sv
package timer8_pkg;

  // register word offsets on the bus
  localparam logic [4:0] control_offset  = 5'h00;
  localparam logic [4:0] count_offset    = 5'h04;
  localparam logic [4:0] compare_offset  = 5'h08;
  localparam logic [4:0] flags_offset    = 5'h0c;
  localparam logic [4:0] port_offset     = 5'h10;

  // flags register fields
  localparam int overflow_flag_bit = 0;
  localparam int compare_flag_bit  = 1;
  // port register fields
  localparam int port_value_bit    = 0;
  localparam int port_dir_bit      = 1;

  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [7:0] count_reset   = 8'h00;
  localparam logic [7:0] compare_reset = 8'h00;
  localparam logic [7:0] max_value     = 8'hff;
  localparam logic [7:0] bottom_value  = 8'h00;

  // clock select codes
  localparam logic [2:0] cs_stopped  = 3'h0;
  localparam logic [2:0] cs_div1     = 3'h1;
  localparam logic [2:0] cs_div8     = 3'h2;
  localparam logic [2:0] cs_div64    = 3'h3;
  localparam logic [2:0] cs_div256   = 3'h4;
  localparam logic [2:0] cs_div1024  = 3'h5;
  localparam logic [2:0] cs_ext_fall = 3'h6;
  localparam logic [2:0] cs_ext_rise = 3'h7;

  // prescaler low-bit masks for each division
  localparam logic [9:0] mask_div8    = 10'h007;
  localparam logic [9:0] mask_div64   = 10'h03f;
  localparam logic [9:0] mask_div256  = 10'h0ff;
  localparam logic [9:0] mask_div1024 = 10'h3ff;

  // compare output modes
  localparam logic [1:0] com_off    = 2'h0;
  localparam logic [1:0] com_toggle = 2'h1;
  localparam logic [1:0] com_clear  = 2'h2;
  localparam logic [1:0] com_set    = 2'h3;

  typedef enum logic [1:0] {
    mode_normal = 2'b00,
    mode_phase  = 2'b01,
    mode_ctc    = 2'b10,
    mode_fast   = 2'b11
  } mode_type;

  // field layout of timer2_control, bit 7 down to bit 0
  typedef struct packed {
    logic       force_compare_strobe;
    logic       waveform_mode_high_bit;
    logic [1:0] compare_output_mode;
    logic       waveform_mode_low_bit;
    logic [2:0] clock_select;
  } control_type;

  // captured address phase
  typedef struct packed {
    logic       write;
    logic [4:0] addr;
  } bus_req_type;

endpackage

// ===== verification/count_pin_driver.sv
`timescale 1ns/1ps
// drives the external count pin; each level is held seven clocks so the
// synchroniser and edge detector always see it
module count_pin_driver (
  input  wire logic clock,
  output logic      pin
);
  initial pin = 1'b0;

  task automatic drive(input logic v);
    @(posedge clock);
    pin <= v;
    repeat (6) @(posedge clock);
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      drive(1'b1);
      drive(1'b0);
    end
  endtask
endmodule

// ===== verification/timer8_waveform_generator_tb.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  bad_count++; $display("MISMATCH %0t: got %h want %h", $time, got, exp); \
  end end
module timer8_waveform_generator_tb;
  localparam logic [4:0] a_ctl = timer8_pkg::control_offset;
  localparam logic [4:0] a_cnt = timer8_pkg::count_offset;
  localparam logic [4:0] a_cmp = timer8_pkg::compare_offset;
  localparam logic [4:0] a_flg = timer8_pkg::flags_offset;
  localparam logic [4:0] a_prt = timer8_pkg::port_offset;
  logic        clock;
  logic        reset;
  logic        enable;
  logic        sel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic        ext_pin;
  logic        cmp_ack;
  logic        ovf_ack;
  logic        pin_out;
  logic        pin_oe;
  logic        cmp_flag;
  logic        ovf_flag;
  logic [31:0] rdata;
  int          bad_count;
  int          n_tests;
  int          cycles;

  timer8_waveform_generator u_dut (
    .clock               (clock),
    .reset               (reset),
    .clock_enable        (enable),
    .hsel                (sel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (3'h2),
    .hwdata              (hwdata),
    .hready              (hready),
    .hreadyout           (hready),
    .hrdata              (hrdata),
    .hresp               (hresp),
    .external_count_pin  (ext_pin),
    .compare_vector_ack  (cmp_ack),
    .overflow_vector_ack (ovf_ack),
    .compare_pin_out     (pin_out),
    .compare_pin_oe      (pin_oe),
    .compare_flag        (cmp_flag),
    .overflow_flag       (ovf_flag)
  );

  count_pin_driver u_pin (
    .clock (clock),
    .pin   (ext_pin)
  );

  initial clock = 1'b0;
  always #12.5 clock = ~clock;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // no wait count is assumed; only the cap stops a dead slave
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr  <= {27'h0, a};
    hwrite <= w;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 40);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 40);
    rdata = hrdata;
    if (n >= 40)
      bad_count++;
  endtask

  task automatic chk(input logic [4:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0);
    `CHECK(rdata, {24'h0, e})
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] m,
      input logic [1:0] com, input logic [2:0] cs, input logic foc);
    timer8_pkg::control_type c;
    c.force_compare_strobe   = foc & ~m[0];
    c.waveform_mode_high_bit = m[1];
    c.waveform_mode_low_bit  = m[0];
    c.compare_output_mode    = com;
    c.clock_select           = cs;
    return {24'h0, c};
  endfunction

  task automatic ack(input logic c);
    if (c) cmp_ack <= 1'b1;
    else ovf_ack <= 1'b1;
    @(posedge clock);
    cmp_ack <= 1'b0;
    ovf_ack <= 1'b0;
    @(posedge clock);
  endtask

  task automatic t_reset();
    chk(a_ctl, 8'h00);
    chk(a_cnt, 8'h00);
    chk(a_cmp, 8'h00);
    chk(a_flg, 8'h00);
    chk(5'h14, 8'h00);
    `CHECK(pin_oe, 1'b0)
    xfer(1'b1, a_ctl, ctl(2'h0, 2'h0, 3'h0, 1'b1));
    chk(a_ctl, 8'h00);
    xfer(1'b1, a_prt, 32'h2);
    repeat (2) @(posedge clock);
    `CHECK(pin_oe, 1'b1)
    $display("done: reset");
  endtask

  task automatic t_force();
    logic [7:0] coms;
    logic [3:0] exps;
    coms = 8'b01_01_10_11;
    exps = 4'b0101;
    xfer(1'b1, a_cnt, 32'h05);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, a_ctl, ctl(2'h2, coms[2*i+:2], 3'h0, 1'b1));
      repeat (2) @(posedge clock);
      `CHECK(pin_out, exps[i])
    end
    chk(a_cnt, 8'h05);
    `CHECK(cmp_flag, 1'b0)
    xfer(1'b1, a_ctl, ctl(2'h2, 2'h0, 3'h0, 1'b0));
    xfer(1'b1, a_prt, 32'h3);
    repeat (2) @(posedge clock);
    `CHECK(pin_out, 1'b1)
    xfer(1'b1, a_prt, 32'h2);
    $display("done: force");
  endtask

  task automatic t_normal();
    xfer(1'b1, a_cmp, 32'hfe);
    xfer(1'b1, a_cnt, 32'hfd);
    xfer(1'b1, a_ctl, ctl(2'h0, 2'h1, 3'h7, 1'b0));
    u_pin.pulse(3);
    chk(a_cnt, 8'h00);
    `CHECK(ovf_flag, 1'b1)
    `CHECK(cmp_flag, 1'b1)
    `CHECK(pin_out, 1'b1)
    xfer(1'b1, a_flg, 32'h3);
    chk(a_flg, 8'h00);
    // tick right after a count write must not match
    xfer(1'b1, a_cmp, 32'h10);
    xfer(1'b1, a_cnt, 32'h10);
    u_pin.pulse(1);
    `CHECK(cmp_flag, 1'b0)
    xfer(1'b1, a_cnt, 32'h0f);
    u_pin.pulse(2);
    `CHECK(cmp_flag, 1'b1)
    ack(1'b1);
    `CHECK(cmp_flag, 1'b0)
    $display("done: normal");
  endtask

  task automatic t_ctc();
    xfer(1'b1, a_cmp, 32'h03);
    xfer(1'b1, a_cnt, 32'h00);
    xfer(1'b1, a_flg, 32'h3);
    xfer(1'b1, a_ctl, ctl(2'h2, 2'h2, 3'h7, 1'b1));
    u_pin.pulse(4);
    chk(a_cnt, 8'h00);
    u_pin.pulse(1);
    chk(a_cnt, 8'h01);
    `CHECK(ovf_flag, 1'b0)
    `CHECK(pin_out, 1'b0)
    $display("done: ctc");
  endtask

  task automatic t_fast();
    xfer(1'b1, a_ctl, ctl(2'h3, 2'h2, 3'h7, 1'b0));
    xfer(1'b1, a_cmp, 32'h02);
    xfer(1'b1, a_cnt, 32'hfe);
    u_pin.pulse(2);
    chk(a_cnt, 8'h00);
    `CHECK(ovf_flag, 1'b1)
    `CHECK(pin_out, 1'b1)
    u_pin.pulse(3);
    `CHECK(pin_out, 1'b0)
    ack(1'b0);
    `CHECK(ovf_flag, 1'b0)
    xfer(1'b1, a_flg, 32'h3);
    xfer(1'b1, a_cmp, 32'h04);
    chk(a_cmp, 8'h04);
    u_pin.pulse(2);
    `CHECK(cmp_flag, 1'b0)
    $display("done: fast");
  endtask

  task automatic t_phase();
    xfer(1'b1, a_ctl, ctl(2'h1, 2'h2, 3'h7, 1'b0));
    xfer(1'b1, a_cmp, 32'h80);
    xfer(1'b1, a_cnt, 32'hfe);
    xfer(1'b1, a_flg, 32'h3);
    u_pin.pulse(1);
    chk(a_cnt, 8'hff);
    `CHECK(ovf_flag, 1'b0)
    `CHECK(pin_out, 1'b0)
    u_pin.pulse(1);
    chk(a_cnt, 8'hfe);
    xfer(1'b1, a_cnt, 32'h82);
    u_pin.pulse(3);
    chk(a_cnt, 8'h7f);
    `CHECK(pin_out, 1'b1)
    xfer(1'b1, a_cnt, 32'h02);
    u_pin.pulse(3);
    chk(a_cnt, 8'h01);
    `CHECK(ovf_flag, 1'b1)
    xfer(1'b1, a_cmp, 32'h00);
    xfer(1'b1, a_cnt, 32'hfd);
    u_pin.pulse(3);
    `CHECK(pin_out, 1'b0)
    $display("done: phase");
  endtask

  task automatic t_clk();
    int divs[6];
    divs = '{0, 1, 8, 64, 256, 1024};
    // prescaler phase is free running, so allow a small window
    for (int k = 1; k < 6; k++) begin
      xfer(1'b1, a_cnt, 32'h00);
      xfer(1'b1, a_ctl, ctl(2'h0, 2'h0, k[2:0], 1'b0));
      repeat (16 * divs[k]) @(posedge clock);
      xfer(1'b1, a_ctl, ctl(2'h0, 2'h0, 3'h0, 1'b0));
      xfer(1'b0, a_cnt, 32'h0);
      `CHECK(rdata[7:0] inside {[8'h0f:8'h12]}, 1'b1)
    end
    // enable low must freeze the counter; two ticks come from the stop write
    xfer(1'b1, a_cnt, 32'h00);
    xfer(1'b1, a_ctl, ctl(2'h0, 2'h0, 3'h1, 1'b0));
    enable <= 1'b0;
    repeat (20) @(posedge clock);
    enable <= 1'b1;
    xfer(1'b1, a_ctl, ctl(2'h0, 2'h0, 3'h0, 1'b0));
    chk(a_cnt, 8'h02);
    xfer(1'b1, a_cnt, 32'h00);
    xfer(1'b1, a_ctl, ctl(2'h0, 2'h0, 3'h6, 1'b0));
    u_pin.drive(1'b1);
    chk(a_cnt, 8'h00);
    u_pin.drive(1'b0);
    chk(a_cnt, 8'h01);
    $display("done: clock select");
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    reset   = 1'b1;
    enable  = 1'b1;
    sel     = 1'b1;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hwdata  = 32'h0;
    cmp_ack = 1'b0;
    ovf_ack = 1'b0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset();
    t_force();
    t_normal();
    t_ctc();
    t_fast();
    t_phase();
    t_clk();
    finish_test();
  end
endmodule
